// ==== logic/spisf_pkg.sv ====
// ----------------------------------------------------------------------------
// Shared constants and carriers for the serial slave port.
// ----------------------------------------------------------------------------
package spisf_pkg;

  // --------------------------------------------------------------------------
  // Widths and counts.
  // --------------------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W  = 3;
  localparam logic [2:0]  BIT_MSB = 3'h7;   // Index of the first bit on the wire.
  localparam logic [2:0]  CNT_ONE = 3'h1;

  // --------------------------------------------------------------------------
  // Control register field positions.
  // --------------------------------------------------------------------------
  localparam int unsigned CTL_DONE_BIT = 7;
  localparam int unsigned CTL_WRITE_COLLISION_FLAG_BIT = 6;
  localparam int unsigned CTL_MODE_FAULT_FLAG_BIT = 5;
  localparam int unsigned CTL_OVRN_BIT = 4;
  localparam int unsigned CTL_SMHI_BIT = 3;
  localparam int unsigned CTL_SMLO_BIT = 2;
  localparam int unsigned CTL_TXMT_BIT = 1;
  localparam int unsigned CTL_EN_BIT   = 0;

  // --------------------------------------------------------------------------
  // Select modes, encoded as {select_mode_hi, select_mode_lo}.
  // --------------------------------------------------------------------------
  localparam logic [1:0] SEL_3WIRE = 2'h0;
  localparam logic [1:0] SEL_4WIRE = 2'h1;   // Also multi-master when mastering.
  localparam logic [1:0] SEL_RESET = SEL_4WIRE;

  // Software-written configuration.
  typedef struct packed {
    logic [1:0] select_mode;      // {select_mode_hi, select_mode_lo}.
    logic       master_enable_bit;
    logic       port_enable_bit;
  } spisf_ctrl_t;

  // Sticky status flags, most significant first as in the control register.
  typedef struct packed {
    logic byte_done_flag;
    logic write_collision_flag;
    logic mode_fault_flag;
    logic receive_overrun_flag;
  } spisf_flags_t;

  localparam spisf_ctrl_t  CTRL_RESET  = '{select_mode: SEL_RESET,
                                           master_enable_bit: 1'b0,
                                           port_enable_bit: 1'b0};
  localparam spisf_flags_t FLAGS_RESET = '0;

endpackage : spisf_pkg

// ==== logic/spisf_port.sv ====
`timescale 1ns/1ns
// Function
// - Enabled with master_enable_bit clear, the port is a slave; never drives clock.
// - External master drives the serial clock; bytes shift in on MOSI, out MISO.
// - A bit counter counts clock edges; eight bits set byte_done_flag, copy byte.
// - Reading serial_data_port returns the receive buffer.
// - A slave never starts a transfer; the master always does.
// - Writes go to transmit buffer; empty shift register takes it at once.
// - Otherwise the shift register loads after the last edge of the transfer.
// - Select mode 01 is four-wire, the default, with select as digital input.
// - Four-wire: respond to clock only while slave_select_n is low.
// - Four-wire: every falling edge of slave_select_n resets the bit counter.
// - Select mode 00 is three-wire; the select signal is unused.
// - Three-wire: only clearing then setting port_enable_bit resets the counter.
// - Enabled interrupts fire on any set flag; only software clears flags.
// - byte_done_flag, bit 7, sets at every completed byte in all modes.
// - Write while transmit buffer full sets write_collision_flag, bit 6; dropped.
// - Multi-master fault on select low sets mode_fault_flag, clears both enables.
// - Slave overrun sets receive_overrun_flag, bit 4; old byte kept, new dropped.
module spisf_port
  import spisf_pkg::*;
(
  // System clock and reset.
  input  wire logic                clk,
  input  wire logic                rst_b,
  // Serial pins; the serial clock clocks the link-side logic.
  input  wire logic                sck,
  input  wire logic                mosi,
  input  wire logic                slave_select_n,
  output logic                     miso,
  output logic                     miso_oe,
  output logic                     sck_out,
  output logic                     sck_oe,
  // Control register access from software.
  input  wire logic                ctrl_wr,
  input  wire spisf_ctrl_t         ctrl_wdata,
  input  wire spisf_flags_t        flag_clr,
  input  wire logic                int_enable,
  output logic [DATA_W-1:0]        port_control_reg,
  output logic                     master_enable_bit,
  output logic                     irq,
  // Data port access from software.
  input  wire logic                data_wr,
  input  wire logic [DATA_W-1:0]   data_wdata,
  input  wire logic                data_rd,
  output logic [DATA_W-1:0]        serial_data_port
);

  // --------------------------------------------------------------------------
  // Declarations.
  // --------------------------------------------------------------------------
  spisf_ctrl_t          ctrl;
  spisf_ctrl_t          next_ctrl;
  spisf_flags_t         flags;
  spisf_flags_t         next_flags;
  logic [DATA_W-1:0]    rx_buf;
  logic [DATA_W-1:0]    next_rx_buf;
  logic                 rx_full;
  logic                 next_rx_full;
  logic [DATA_W-1:0]    tx_buf;
  logic [DATA_W-1:0]    next_tx_buf;
  logic                 tx_full;
  logic                 next_tx_full;
  logic [DATA_W-1:0]    tx_shreg;
  logic [DATA_W-1:0]    next_tx_shreg;
  logic                 shreg_full;
  logic                 next_shreg_full;
  logic                 done_d;
  logic                 next_done_d;
  logic                 done_s;
  logic                 nss_s;
  logic                 byte_evt;
  logic                 slave_on;
  logic                 four_wire;
  logic                 mode_fault;
  logic                 link_rst_b;
  // Link-side state.
  logic [CNT_W-1:0]     cnt;
  logic [CNT_W-1:0]     next_cnt;
  logic [DATA_W-2:0]    rx_sh;
  logic [DATA_W-2:0]    next_rx_sh;
  logic [DATA_W-1:0]    rx_word;
  logic [DATA_W-1:0]    next_rx_word;
  logic                 done_tgl;
  logic                 next_done_tgl;

  // --------------------------------------------------------------------------
  // Mode decode.
  // --------------------------------------------------------------------------
  // Slave whenever enabled without mastering; any select mode other than
  // four-wire leaves the select input unused, as in three-wire operation.
  assign slave_on   = ctrl.port_enable_bit && !ctrl.master_enable_bit;
  assign four_wire  = ctrl.select_mode == SEL_4WIRE;
  assign mode_fault = ctrl.port_enable_bit && ctrl.master_enable_bit
                      && four_wire && !nss_s;

  // The link logic is held cleared while the port is off or, in four-wire
  // mode, while the select is high, so each select fall starts at bit zero.
  // All terms come from flip-flops, which keeps this reset free of glitches;
  // the two-stage select path is why the master must lead by two clocks.
  assign link_rst_b = rst_b && slave_on
                      && !(four_wire && nss_s);

  // The port never makes the serial clock.
  assign sck_out = 1'b0;
  assign sck_oe  = 1'b0;

  // --------------------------------------------------------------------------
  // Synchronisers into the system clock domain.
  // --------------------------------------------------------------------------
  spisf_sync2 #(.RESET_VAL(1'b1)) u_nss_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (slave_select_n),
    .sync_out (nss_s)
  );

  spisf_sync2 #(.RESET_VAL(1'b0)) u_done_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (done_tgl),
    .sync_out (done_s)
  );

  // A change of the synchronised toggle marks one completed byte.
  assign byte_evt = done_s ^ done_d;

  // --------------------------------------------------------------------------
  // Link side: bit counter and receive shifter on the serial clock.
  // --------------------------------------------------------------------------
  // Bits are sampled on the rising serial clock edge, first bit MSB.
  always_comb begin
    next_cnt      = cnt + CNT_ONE;
    next_rx_sh    = {rx_sh[DATA_W-3:0], mosi};
    next_rx_word  = rx_word;
    next_done_tgl = done_tgl;
    if (cnt == BIT_MSB) begin
      next_rx_word  = {rx_sh, mosi};
      next_done_tgl = ~done_tgl;
    end
  end

  // The word and toggle survive a link reset so a finished byte is not lost.
  always_ff @(posedge sck or negedge link_rst_b) begin
    if (!link_rst_b) begin
      cnt   <= '0;
      rx_sh <= '0;
    end else begin
      cnt   <= next_cnt;
      rx_sh <= next_rx_sh;
    end
  end

  always_ff @(posedge sck or negedge rst_b) begin
    if (!rst_b) begin
      rx_word  <= '0;
      done_tgl <= 1'b0;
    end else begin
      rx_word  <= next_rx_word;
      done_tgl <= next_done_tgl;
    end
  end

  // The transmit byte is held steady by the system side for a whole byte,
  // so the pin may select its bit by the link counter without a crossing.
  assign miso    = tx_shreg[BIT_MSB - cnt];
  // The enable follows the synchronised select, so the raw pin feeds no logic;
  // the two-clock lead of the select covers the lag before the first bit.
  assign miso_oe = slave_on && (!four_wire || !nss_s);

  // --------------------------------------------------------------------------
  // System side: buffers, flags and control.
  // --------------------------------------------------------------------------
  always_comb begin
    next_ctrl       = ctrl;
    next_flags      = flags;
    next_rx_buf     = rx_buf;
    next_rx_full    = rx_full;
    next_tx_buf     = tx_buf;
    next_tx_full    = tx_full;
    next_tx_shreg   = tx_shreg;
    next_shreg_full = shreg_full;
    next_done_d     = done_s;
    // Software clears come first so that a same-cycle set wins.
    next_flags = flags & ~flag_clr;
    if (ctrl_wr) begin
      next_ctrl = ctrl_wdata;
    end
    if (data_rd) begin
      next_rx_full = 1'b0;
    end
    // End of a byte: report it, capture it, refill the shifter.
    if (byte_evt) begin
      next_flags.byte_done_flag = 1'b1;
      if (rx_full && !data_rd) begin
        next_flags.receive_overrun_flag = 1'b1;
      end else begin
        next_rx_buf  = rx_word;
        next_rx_full = 1'b1;
      end
      if (tx_full) begin
        next_tx_shreg   = tx_buf;
        next_shreg_full = 1'b1;
        next_tx_full    = 1'b0;
      end else begin
        next_shreg_full = 1'b0;
      end
    end
    // A software write after any refill of this cycle.
    if (data_wr) begin
      if (next_tx_full) begin
        next_flags.write_collision_flag = 1'b1;
      end else if (!next_shreg_full) begin
        next_tx_shreg   = data_wdata;
        next_shreg_full = 1'b1;
      end else begin
        next_tx_buf  = data_wdata;
        next_tx_full = 1'b1;
      end
    end
    // A mode fault hands the bus to the other master.
    if (mode_fault) begin
      next_flags.mode_fault_flag        = 1'b1;
      next_ctrl.master_enable_bit       = 1'b0;
      next_ctrl.port_enable_bit         = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl       <= CTRL_RESET;
      flags      <= FLAGS_RESET;
      rx_buf     <= '0;
      rx_full    <= 1'b0;
      tx_buf     <= '0;
      tx_full    <= 1'b0;
      tx_shreg   <= '0;
      shreg_full <= 1'b0;
      done_d     <= 1'b0;
    end else begin
      ctrl       <= next_ctrl;
      flags      <= next_flags;
      rx_buf     <= next_rx_buf;
      rx_full    <= next_rx_full;
      tx_buf     <= next_tx_buf;
      tx_full    <= next_tx_full;
      tx_shreg   <= next_tx_shreg;
      shreg_full <= next_shreg_full;
      done_d     <= next_done_d;
    end
  end

  // --------------------------------------------------------------------------
  // Software-visible outputs.
  // --------------------------------------------------------------------------
  // Status view; flags sit in the high nibble as software expects them.
  always_comb begin
    port_control_reg               = '0;
    port_control_reg[CTL_DONE_BIT] = flags.byte_done_flag;
    port_control_reg[CTL_WRITE_COLLISION_FLAG_BIT] = flags.write_collision_flag;
    port_control_reg[CTL_MODE_FAULT_FLAG_BIT] = flags.mode_fault_flag;
    port_control_reg[CTL_OVRN_BIT] = flags.receive_overrun_flag;
    port_control_reg[CTL_SMHI_BIT] = ctrl.select_mode[1];
    port_control_reg[CTL_SMLO_BIT] = ctrl.select_mode[0];
    port_control_reg[CTL_TXMT_BIT] = !tx_full;
    port_control_reg[CTL_EN_BIT]   = ctrl.port_enable_bit;
  end

  assign master_enable_bit = ctrl.master_enable_bit;
  assign serial_data_port  = rx_buf;
  assign irq               = int_enable && (|flags);

  // --------------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------------
  // Properties run on the system clock; reset disables them all.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_done_on_byte: assert property (byte_evt |=> flags.byte_done_flag)
    else $error("Byte end did not set the done flag.");

  a_rx_capture: assert property (
    byte_evt && !rx_full |=> rx_full && serial_data_port == $past(rx_word))
    else $error("Completed byte was not copied to the receive buffer.");

  a_overrun_keep: assert property (
    byte_evt && rx_full && !data_rd
    |=> flags.receive_overrun_flag && $stable(serial_data_port))
    else $error("Overrun did not keep the old byte and set its flag.");

  a_write_collision_flag_drop: assert property (
    data_wr && tx_full && !byte_evt
    |=> flags.write_collision_flag && $stable(tx_buf) && tx_full)
    else $error("Colliding write was not dropped.");

  a_tx_direct: assert property (
    data_wr && !shreg_full && !tx_full && !byte_evt
    |=> shreg_full && tx_shreg == $past(data_wdata) && !tx_full)
    else $error("Write to an empty shifter did not load it at once.");

  a_tx_reload: assert property (
    byte_evt && tx_full && !data_wr
    |=> !tx_full && shreg_full && tx_shreg == $past(tx_buf))
    else $error("Buffered byte did not move at the end of a byte.");

  a_mode_fault: assert property (
    mode_fault && !ctrl_wr |=> flags.mode_fault_flag
    && !port_control_reg[CTL_EN_BIT] && !master_enable_bit)
    else $error("Mode fault did not disable the port.");

  a_flag_sticky: assert property (
    flags.byte_done_flag && !flag_clr.byte_done_flag
    |=> flags.byte_done_flag [*2] or flag_clr.byte_done_flag)
    else $error("Done flag fell without a software clear.");

  a_irq_follow: assert property (
    int_enable && $rose(flags.write_collision_flag) |-> irq)
    else $error("Set flag did not raise the interrupt.");

  // The link count is looked at only while it is held cleared, so the serial
  // clock cannot race this check.
  a_link_hold: assert property (
    four_wire && nss_s |-> cnt == '0 && !miso_oe)
    else $error("Link ran while the select was high.");

  a_read_mark: assert property (data_rd && !byte_evt |=> !rx_full)
    else $error("Read did not mark the receive buffer as read.");

  a_clock_quiet: assert property (!sck_oe && !sck_out)
    else $error("Slave port drove the serial clock.");

  // Main scenarios: plain byte, overrun, collision, refill, three-wire byte.
  c_byte_done: cover property (byte_evt && !rx_full);
  c_overrun: cover property (byte_evt && rx_full);
  c_collision: cover property (data_wr && tx_full);
  c_reload: cover property (byte_evt && tx_full);
  c_three_wire: cover property (byte_evt && !four_wire);

endmodule : spisf_port

// ==== logic/spisf_sync2.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// Two-stage level synchroniser into the clk domain.
// ----------------------------------------------------------------------------
module spisf_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_b,
  // Asynchronous level in, synchronised level out.
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta;
  logic next_meta;
  logic next_sync_out;

  // The first stage feeds only the second stage.
  always_comb begin
    next_meta     = async_in;
    next_sync_out = meta;
  end

  // Both stages reset to the idle level of the signal.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta     <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta     <= next_meta;
      sync_out <= next_sync_out;
    end
  end

endmodule : spisf_sync2

// ==== tb/spisf_master_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------------------------------------------
// External serial master, clock phase 0, clock idle low between frames.
// ----------------------------------------------------------------------------
module spisf_master_model (
  // Serial pins toward the slave.
  output logic      sck,
  output logic      mosi,
  output logic      slave_select_n,
  input  wire logic miso
);
  // Idle pins: clock still, select released.
  initial begin
    sck            = 1'b0;
    mosi           = 1'b0;
    slave_select_n = 1'b1;
  end

  // Direct control of the select pin, used to provoke a mode fault.
  task automatic select(input logic lvl);
    slave_select_n = lvl;
  endtask : select

  // One frame of nbits clock pulses at 160 ns; the slave's answer is sampled on each rise.
  // Without use_sel the select stays released, as for the sole slave in three-wire mode.
  task automatic frame(input logic [7:0] tx, input int nbits, input bit use_sel,
                       output logic [7:0] rx);
    rx = 8'h00;
    if (use_sel) begin
      slave_select_n = 1'b0;
      #40;
    end
    for (int i = 0; i < nbits; i++) begin
      mosi = tx[7-i];
      #80 sck = 1'b1;
      rx = {rx[6:0], miso};
      #80 sck = 1'b0;
    end
    // A released data line must not keep showing the last bit.
    mosi = ~mosi;
    if (use_sel) begin
      #40 slave_select_n = 1'b1;
    end
  endtask : frame
endmodule : spisf_master_model

// ==== tb/tb_spi_slave_port_with_flags.sv ====
`timescale 1ns/1ns
module tb_spi_slave_port_with_flags;
  import spisf_pkg::*;
  logic               clk, rst_b, sck, mosi, slave_select_n, miso, miso_oe, sck_out, sck_oe;
  logic               ctrl_wr, int_enable, data_wr, data_rd, master_enable_bit, irq;
  spisf_ctrl_t        ctrl_wdata;
  spisf_flags_t       flag_clr;
  logic [DATA_W-1:0]  port_control_reg, data_wdata, serial_data_port;
  logic [7:0]         t0, t1, t2, b, got;
  logic [31:0]        seed;
  int                 n_errors, cmp_count;

  spisf_port uut (.clk(clk), .rst_b(rst_b), .sck(sck), .mosi(mosi),
    .slave_select_n(slave_select_n), .miso(miso), .miso_oe(miso_oe), .sck_out(sck_out),
    .sck_oe(sck_oe), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .flag_clr(flag_clr),
    .int_enable(int_enable), .port_control_reg(port_control_reg),
    .master_enable_bit(master_enable_bit), .irq(irq), .data_wr(data_wr),
    .data_wdata(data_wdata), .data_rd(data_rd), .serial_data_port(serial_data_port));
  spisf_master_model m (.sck(sck), .mosi(mosi), .slave_select_n(slave_select_n), .miso(miso));

  // ----------------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------------
  // Xorshift keeps the random bytes repeatable across simulators.
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  // Expected control view: flags, select mode, transmit buffer empty, enable.
  function automatic logic [7:0] exp_ctl(input logic [3:0] flg, input logic [1:0] sm,
                                         input logic txe, input logic en);
    return {flg, sm, txe, en};
  endfunction : exp_ctl

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t byte got %h expected %h", $time, g, e);
    end
  endtask : chk8

  task automatic chk1(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t bit got %b expected %b", $time, g, e);
    end
  endtask : chk1

  // Every strobe is one cycle long; outputs are looked at after that edge settles.
  task automatic strobe_end();
    @(posedge clk);
    ctrl_wr  <= 1'b0;
    data_wr  <= 1'b0;
    data_rd  <= 1'b0;
    flag_clr <= '0;
    #1;
  endtask : strobe_end

  task automatic sw_ctrl(input logic [1:0] sm, input logic me, input logic en);
    @(posedge clk);
    ctrl_wr    <= 1'b1;
    ctrl_wdata <= '{select_mode: sm, master_enable_bit: me, port_enable_bit: en};
    strobe_end();
  endtask : sw_ctrl

  task automatic sw_wr(input logic [7:0] d);
    @(posedge clk);
    data_wr    <= 1'b1;
    data_wdata <= d;
    strobe_end();
  endtask : sw_wr

  task automatic sw_rd();
    @(posedge clk);
    data_rd <= 1'b1;
    strobe_end();
  endtask : sw_rd

  task automatic sw_clr();
    @(posedge clk);
    flag_clr <= '1;
    strobe_end();
  endtask : sw_clr

  // The completion needs three to four system clocks; eight leaves margin.
  task automatic xfer(input logic [7:0] d, input int n, input bit use_sel);
    m.frame(d, n, use_sel, got);
    repeat (8) @(posedge clk);
    #1;
  endtask : xfer

  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------------------
  // Clock, watchdog and scenarios.
  // ----------------------------------------------------------------------------
  // System clock of 4 ns.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Twelve frames of up to 1.4 us each are expected; the limit allows ample slack.
  initial begin
    #200000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    close_out();
  end

  initial begin
    {ctrl_wr, data_wr, data_rd, int_enable} = 4'h0;
    ctrl_wdata = CTRL_RESET;
    flag_clr   = '0;
    data_wdata = 8'h00;
    n_errors   = 0;
    cmp_count  = 0;
    seed       = 32'h00000047;
    rst_b      = 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    chk8(port_control_reg, exp_ctl(4'h0, SEL_4WIRE, 1'b1, 1'b0));
    chk1(sck_oe, 1'b0);
    chk1(sck_out, 1'b0);
    $display("test reset view ended");
    // Double buffering, collision, overrun and read marking in four-wire mode.
    sw_ctrl(SEL_4WIRE, 1'b0, 1'b1);
    t0 = rnd();
    t1 = rnd();
    t2 = rnd();
    sw_wr(t0);
    chk8(port_control_reg, exp_ctl(4'h0, SEL_4WIRE, 1'b1, 1'b1));
    sw_wr(t1);
    chk8(port_control_reg, exp_ctl(4'h0, SEL_4WIRE, 1'b0, 1'b1));
    sw_wr(rnd());
    chk8(port_control_reg, exp_ctl(4'h4, SEL_4WIRE, 1'b0, 1'b1));
    b = rnd();
    xfer(b, 8, 1'b1);
    chk8(got, t0);
    chk8(port_control_reg, exp_ctl(4'hC, SEL_4WIRE, 1'b1, 1'b1));
    chk8(serial_data_port, b);
    chk1(sck_oe, 1'b0);
    @(posedge clk);
    int_enable <= 1'b1;
    strobe_end();
    chk1(irq, 1'b1);
    repeat (20) @(posedge clk);
    chk1(port_control_reg[7], 1'b1);
    sw_clr();
    chk1(irq, 1'b0);
    sw_wr(t2);
    chk8(port_control_reg, exp_ctl(4'h0, SEL_4WIRE, 1'b0, 1'b1));
    xfer(8'hFF, 8, 1'b1);
    chk8(got, t1);
    chk8(serial_data_port, b);
    chk1(port_control_reg[4], 1'b1);
    sw_rd();
    sw_clr();
    b = rnd();
    xfer(b, 8, 1'b1);
    chk8(got, t2);
    chk8(serial_data_port, b);
    chk1(port_control_reg[4], 1'b0);
    for (int i = 0; i < 4; i++) begin
      sw_rd();
      t0 = rnd();
      b  = rnd();
      sw_wr(t0);
      xfer(b, 8, 1'b1);
      chk8(got, t0);
      chk8(serial_data_port, b);
    end
    $display("test four-wire traffic ended");
    // A partial byte is dropped once select rises; an unselected port ignores the clock.
    sw_rd();
    sw_clr();
    xfer(8'hA5, 3, 1'b1);
    chk1(port_control_reg[7], 1'b0);
    b = rnd();
    xfer(b, 8, 1'b1);
    chk8(serial_data_port, b);
    sw_rd();
    sw_clr();
    xfer(rnd(), 8, 1'b0);
    chk1(port_control_reg[7], 1'b0);
    chk1(miso_oe, 1'b0);
    m.select(1'b0);
    repeat (4) @(posedge clk);
    #1;
    chk1(miso_oe, 1'b1);
    m.select(1'b1);
    repeat (4) @(posedge clk);
    $display("test select handling ended");
    // Three-wire mode: only an enable toggle realigns the bit counter.
    sw_ctrl(SEL_3WIRE, 1'b0, 1'b1);
    xfer(8'h3C, 5, 1'b0);
    sw_ctrl(SEL_3WIRE, 1'b0, 1'b0);
    sw_ctrl(SEL_3WIRE, 1'b0, 1'b1);
    b = rnd();
    xfer(b, 8, 1'b0);
    chk8(serial_data_port, b);
    chk1(port_control_reg[7], 1'b1);
    $display("test three-wire mode ended");
    // Mode fault while mastering with the select pulled low.
    sw_clr();
    sw_ctrl(SEL_4WIRE, 1'b1, 1'b1);
    m.select(1'b0);
    repeat (6) @(posedge clk);
    #1;
    chk1(port_control_reg[5], 1'b1);
    chk1(port_control_reg[0], 1'b0);
    chk1(master_enable_bit, 1'b0);
    m.select(1'b1);
    $display("test mode fault ended");
    close_out();
  end
endmodule : tb_spi_slave_port_with_flags
